// file: include/std_pkg.sv
// constants, types and register layout for the slot type detect and host feature block
// assumes a single 100 MHz core clock and an asynchronous active-low reset
// Behaviour
// RULE1 - classify slot as 16-bit, CardBus or dock
// RULE2 - 3.3V dock: CD2 gnd, CD1-VS1, VS2 gnd
// RULE3 - 5.0V dock: CD2 gnd, CD1-VS2, VS1 gnd
// RULE4 - one CD grounded, other tied: CardBus
// RULE5 - both CD grounded: 16-bit; opens+5V key: 5V
// RULE6 - 16-bit low-voltage key sense decode
// RULE7 - slot mux chosen by hardware from detect
// RULE8 - mux applies programmable levels and slew
// RULE9 - dock only on slot A when enabled
// RULE10 - 16-bit card never masters primary bus
// RULE11 - 16-bit hides secondary bus, config still reachable
// RULE12 - CardBus card: only device 0 responds
// RULE13 - config sets are functions 0 and 1
// RULE14 - standard 00h-47h, device-specific 48h-FFh
// RULE15 - any bus master may program config
// RULE16 - device may drive clock-run low
// RULE17 - feature bit 2 disables clock-run, tristates
// RULE18 - dock attached forces running clock request
// RULE19 - feature bit 3 selects debounce interval
// RULE20 - feature bit 1 tristates or drives speaker
// RULE21 - feature bits 7:4 report straps, read-only
// RULE22 - feature register shared, resets to 00h
// RULE23 - classification updates after stable debounce only; code drops a committed dock to bad at once when dock enable clears
package std_pkg;
    localparam int NSLOT = 2;
    localparam int PAT_W = 7;

    typedef enum logic [2:0] {TY_NONE, TY_PCM, TY_CBUS, TY_DOCK, TY_BAD} std_type_e;
    typedef enum logic [2:0] {
        VT_NONE, VT_33, VT_5, VT_33_5, VT_XX, VT_XX_33, VT_XX_33_5, VT_OTHER
    } std_volt_e;

    // voltage-sense pad states
    localparam logic [1:0] SENSE_OPEN = 2'h0;
    localparam logic [1:0] SENSE_GND  = 2'h1;
    localparam logic [1:0] SENSE_CD1  = 2'h2;
    localparam logic [1:0] SENSE_CD2  = 2'h3;

    // configuration space
    localparam logic [2:0] FUNC_A        = 3'h0;
    localparam logic [2:0] FUNC_B        = 3'h1;
    localparam logic [7:0] CFG_STD_LAST  = 8'h47;
    localparam logic [7:0] CFG_HOST_FEAT = 8'h50;
    localparam logic [7:0] CFG_SLOT_STAT = 8'h54;
    localparam logic [7:0] CFG_SLOT_CTRL = 8'h55;

    localparam int HF_SPKR       = 1;
    localparam int HF_CLKRUN_DIS = 2;
    localparam int HF_DEB_LONG   = 3;
    localparam logic [7:0] HOST_FEAT_RST   = 8'h00;
    localparam logic [7:0] HOST_FEAT_WMASK = 8'h0e;

    localparam int SC_DOCK_EN  = 0;
    localparam int SC_PCM_LVL5 = 1;
    localparam int SC_PCI_SLEW = 2;
    localparam logic [7:0] SLOT_CTRL_RST   = 8'h00;
    localparam logic [7:0] SLOT_CTRL_WMASK = 8'h07;

    // timing
    localparam int CLK_MHZ      = 100;
    localparam int DEB_SHORT_MS = 250;
    localparam int DEB_LONG_MS  = 1000;
    localparam int DEB_SHORT_CYC = DEB_SHORT_MS * CLK_MHZ * 1000;
    localparam int DEB_LONG_CYC  = DEB_LONG_MS * CLK_MHZ * 1000;
    localparam int DEB_W         = 27;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
endpackage : std_pkg

// file: include/std_slot_if.sv
// signals between the feature controller and one slot detector
// assumes both ends run on core_clk; pin levels arrive already synchronised
interface std_slot_if;
    logic                 cd1N;
    logic                 cd2N;
    logic [1:0]           vs1;
    logic [1:0]           vs2;
    logic                 lvKey;
    logic                 debLong;
    logic                 dockEnable;
    std_pkg::std_type_e   slotType;
    std_pkg::std_volt_e   slotVolt;

    modport det (input cd1N, cd2N, vs1, vs2, lvKey, debLong, dockEnable,
                 output slotType, slotVolt);
    modport ctrl (output cd1N, cd2N, vs1, vs2, lvKey, debLong, dockEnable,
                  input slotType, slotVolt);
endinterface : std_slot_if

// file: design/std_slot_detect.sv
// debounced card type classifier for one slot
// assumes synchronised detect and sense levels on the interface
module std_slot_detect #(
    parameter bit DOCK_CAPABLE = 1'b0,
    parameter int DEB_W        = std_pkg::DEB_W,
    parameter int SHORT_CYC    = std_pkg::DEB_SHORT_CYC,
    parameter int LONG_CYC     = std_pkg::DEB_LONG_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // slot side
    std_slot_if.det  sl
);
    logic [std_pkg::PAT_W-1:0] pat;
    logic [std_pkg::PAT_W-1:0] patPrev;
    logic [std_pkg::PAT_W-1:0] next_patPrev;
    logic [DEB_W-1:0]          cnt;
    logic [DEB_W-1:0]          next_cnt;
    logic [DEB_W-1:0]          limit;
    logic                      full;
    logic                      dockOk;
    std_pkg::std_type_e        rawType;
    std_pkg::std_type_e        next_type;
    std_pkg::std_volt_e        rawVolt;
    std_pkg::std_volt_e        next_volt;

    assign pat    = {sl.cd1N, sl.cd2N, sl.vs1, sl.vs2, sl.lvKey};
    assign dockOk = DOCK_CAPABLE && sl.dockEnable;                         // RULE9

    // pattern decode
    always_comb begin
        rawType = std_pkg::TY_BAD;
        rawVolt = std_pkg::VT_OTHER;
        if (!sl.cd1N && !sl.cd2N) begin
            rawType = std_pkg::TY_PCM;                                     // RULE5
            if (sl.vs1 == std_pkg::SENSE_OPEN && sl.vs2 == std_pkg::SENSE_OPEN && !sl.lvKey)
                rawVolt = std_pkg::VT_5;                                   // RULE5
            else if (sl.vs1 == std_pkg::SENSE_GND && sl.vs2 == std_pkg::SENSE_OPEN)
                rawVolt = sl.lvKey ? std_pkg::VT_33 : std_pkg::VT_33_5;   // RULE6
            else if (sl.vs1 == std_pkg::SENSE_OPEN && sl.vs2 == std_pkg::SENSE_GND && sl.lvKey)
                rawVolt = std_pkg::VT_XX;
            else if (sl.vs1 == std_pkg::SENSE_GND && sl.vs2 == std_pkg::SENSE_GND)
                rawVolt = sl.lvKey ? std_pkg::VT_XX_33 : std_pkg::VT_XX_33_5; // RULE6
            else
                rawType = std_pkg::TY_BAD;
        end else if (!sl.cd2N) begin
            if (sl.vs1 == std_pkg::SENSE_CD1 && sl.vs2 == std_pkg::SENSE_GND) begin
                rawType = std_pkg::TY_DOCK;                                // RULE2
                rawVolt = std_pkg::VT_33;
            end else if (sl.vs2 == std_pkg::SENSE_CD1 && sl.vs1 == std_pkg::SENSE_GND) begin
                rawType = std_pkg::TY_DOCK;                                // RULE3
                rawVolt = std_pkg::VT_5;
            end else if (sl.vs1 == std_pkg::SENSE_CD1 || sl.vs2 == std_pkg::SENSE_CD1) begin
                rawType = std_pkg::TY_CBUS;                                // RULE4
                if (sl.vs1 == std_pkg::SENSE_CD1 && sl.vs2 == std_pkg::SENSE_OPEN)
                    rawVolt = std_pkg::VT_33;
            end
        end else if (!sl.cd1N) begin
            if (sl.vs1 == std_pkg::SENSE_CD2 || sl.vs2 == std_pkg::SENSE_CD2)
                rawType = std_pkg::TY_CBUS;                                // RULE4
        end else begin
            rawType = std_pkg::TY_NONE;
            rawVolt = std_pkg::VT_NONE;
        end
        if (rawType == std_pkg::TY_DOCK && !dockOk)
            rawType = std_pkg::TY_BAD;                                     // RULE9
    end

    // debounce: commit only after the pattern stood still for the interval, except a dock dropping to bad when dock enable clears
    always_comb begin
        limit = sl.debLong ? DEB_W'(LONG_CYC - 1) : DEB_W'(SHORT_CYC - 1); // RULE19
        full  = (pat == patPrev) && (cnt == limit);
        next_patPrev = pat;
        if (pat != patPrev)
            next_cnt = '0;                                                 // RULE23
        else if (cnt < limit)
            next_cnt = cnt + DEB_W'(1);
        else
            next_cnt = cnt;
        next_type = full ? rawType : sl.slotType;                          // RULE23
        next_volt = full ? rawVolt : sl.slotVolt;
        if (next_type == std_pkg::TY_DOCK && !dockOk)
            next_type = std_pkg::TY_BAD;                                   // RULE9
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            patPrev     <= '0;
            cnt         <= '0;
            sl.slotType <= std_pkg::TY_NONE;
            sl.slotVolt <= std_pkg::VT_NONE;
        end else begin
            patPrev     <= next_patPrev;
            cnt         <= next_cnt;
            sl.slotType <= next_type;
            sl.slotVolt <= next_volt;
        end
    end

    property p_commit_stable;
        @(posedge core_clk) disable iff (!nrst)
        $changed(sl.slotType) |-> $past(full) || $past(sl.slotType) == std_pkg::TY_DOCK;
    endproperty
    a_commit_stable: assert property (p_commit_stable) else $error("type changed unstable"); // RULE23

    property p_dock_gated;
        @(posedge core_clk) disable iff (!nrst)
        sl.slotType == std_pkg::TY_DOCK |-> DOCK_CAPABLE && $past(sl.dockEnable);
    endproperty
    a_dock_gated: assert property (p_dock_gated) else $error("dock without enable"); // RULE9

    property p_restart;
        @(posedge core_clk) disable iff (!nrst)
        pat != patPrev |=> cnt == '0 && $stable(sl.slotType);
    endproperty
    a_restart: assert property (p_restart) else $error("debounce not restarted"); // RULE23
endmodule : std_slot_detect

// file: design/std_host_ctrl.sv
// slot type detection, slot mux steering, clock-run and host feature register
// assumes a config-cycle decoder upstream presenting one request per cycle on the cfg port
module std_host_ctrl #(
    parameter int DEB_SHORT_CYC = std_pkg::DEB_SHORT_CYC,
    parameter int DEB_LONG_CYC  = std_pkg::DEB_LONG_CYC
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // slot pins, index 0 is slot A
    input  wire logic [1:0]      cd1N,
    input  wire logic [1:0]      cd2N,
    input  wire logic [1:0][1:0] vs1,
    input  wire logic [1:0][1:0] vs2,
    input  wire logic [1:0]      lowVoltageKey,
    input  wire logic [1:0]      slotSpeaker,
    // reset straps: zoomed video, legacy, identification, irq latch
    input  wire logic [3:0]      strapPins,
    // configuration access
    input  wire logic        cfgReq,
    input  wire logic        cfgWr,
    input  wire logic [2:0]  cfgFunc,
    input  wire logic [7:0]  cfgIndex,
    input  wire logic [7:0]  cfgWdata,
    output logic             cfgAck,
    output logic [7:0]       cfgRdata,
    // clock-run pin and request from the bridge
    input  wire logic        clkrunIn,
    input  wire logic        clkRunReq,
    output logic             clkrunOut,
    output logic             clkrunOe,
    // speaker pin
    output logic             speakerOutDrive,
    output logic             speakerOe,
    // slot steering
    output logic [1:0]       muxPciSel,
    output logic [1:0]       secMasterEn,
    output logic [1:0]       onlyDev0,
    output logic [1:0]       ioLevel5,
    output logic [1:0]       slewFast,
    output logic [1:0][2:0]  slotType,
    output logic [1:0][2:0]  slotVolt
);
    localparam int NS = std_pkg::NSLOT;
    localparam int SYW = 8 * NS + 5;

    // two-flop synchronisers on every pin input
    logic [SYW-1:0] syMeta;
    logic [SYW-1:0] sySync;
    logic [SYW-1:0] pinRaw;
    assign pinRaw = {cd1N, cd2N, vs1, vs2, lowVoltageKey, slotSpeaker, strapPins,
                     clkrunIn};

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            syMeta <= '0;
            sySync <= '0;
        end else begin
            syMeta <= pinRaw;
            sySync <= syMeta;
        end
    end

    logic [1:0]      sCd1N;
    logic [1:0]      sCd2N;
    logic [1:0][1:0] sVs1;
    logic [1:0][1:0] sVs2;
    logic [1:0]      sLv;
    logic [1:0]      sSpk;
    logic [3:0]      sStrap;
    logic            sClkrun;
    assign {sCd1N, sCd2N, sVs1, sVs2, sLv, sSpk, sStrap, sClkrun} = sySync;

    // registers
    logic [7:0]      hfCtrl;
    logic [7:0]      next_hfCtrl;
    logic [3:0]      strapReg;
    logic [3:0]      next_strapReg;
    logic [1:0]      strapCnt;
    logic [1:0]      next_strapCnt;
    logic [NS-1:0][7:0] slotCtrl;
    logic [NS-1:0][7:0] next_slotCtrl;
    logic [7:0]      hfView;
    logic            claim;
    logic            fIdx;

    std_slot_if slotIf[NS] ();

    for (genvar s = 0; s < NS; s++) begin : g_slot
        assign slotIf[s].cd1N       = sCd1N[s];
        assign slotIf[s].cd2N       = sCd2N[s];
        assign slotIf[s].vs1        = sVs1[s];
        assign slotIf[s].vs2        = sVs2[s];
        assign slotIf[s].lvKey      = sLv[s];
        assign slotIf[s].debLong    = hfCtrl[std_pkg::HF_DEB_LONG];        // RULE19
        assign slotIf[s].dockEnable = slotCtrl[s][std_pkg::SC_DOCK_EN];
        std_slot_detect #(
            .DOCK_CAPABLE (s == 0),
            .DEB_W        (std_pkg::DEB_W),
            .SHORT_CYC    (DEB_SHORT_CYC),
            .LONG_CYC     (DEB_LONG_CYC)
        ) u_det (
            .core_clk (core_clk),
            .nrst     (nrst),
            .sl       (slotIf[s])
        );
    end

    std_pkg::std_type_e [NS-1:0] detType;
    std_pkg::std_volt_e [NS-1:0] detVolt;
    for (genvar s = 0; s < NS; s++) begin : g_res
        assign detType[s] = slotIf[s].slotType;
        assign detVolt[s] = slotIf[s].slotVolt;
    end

    // config decode: any master's cycle arriving here is served alike
    assign claim  = cfgReq && (cfgFunc == std_pkg::FUNC_A || cfgFunc == std_pkg::FUNC_B); // RULE13 RULE15
    assign fIdx   = (cfgFunc == std_pkg::FUNC_B);
    assign hfView = (hfCtrl & std_pkg::HOST_FEAT_WMASK) | {strapReg, 4'h0};       // RULE21

    logic [7:0] next_cfgRdata;
    logic       next_cfgAck;

    always_comb begin
        next_hfCtrl   = hfCtrl;
        next_slotCtrl = slotCtrl;
        next_cfgAck   = claim;
        next_cfgRdata = cfgRdata;
        next_strapCnt = strapCnt;
        next_strapReg = strapReg;
        // straps latched once the synchronisers have settled after reset
        if (strapCnt != std_pkg::STRAP_SETTLE)
            next_strapCnt = strapCnt + 2'h1;
        if (strapCnt == std_pkg::STRAP_SETTLE - 2'h1)
            next_strapReg = sStrap;                                        // RULE21
        if (claim) begin
            next_cfgRdata = 8'h00;                                         // RULE14
            if (cfgIndex > std_pkg::CFG_STD_LAST) begin
                unique case (cfgIndex)
                    std_pkg::CFG_HOST_FEAT: next_cfgRdata = hfView;        // RULE22
                    std_pkg::CFG_SLOT_STAT: next_cfgRdata = {2'h0, detVolt[fIdx], detType[fIdx]};
                    std_pkg::CFG_SLOT_CTRL: next_cfgRdata = slotCtrl[fIdx];
                    default:                next_cfgRdata = 8'h00;
                endcase
            end
            if (cfgWr && cfgIndex == std_pkg::CFG_HOST_FEAT)
                next_hfCtrl = cfgWdata & std_pkg::HOST_FEAT_WMASK;         // RULE22
            if (cfgWr && cfgIndex == std_pkg::CFG_SLOT_CTRL) begin
                next_slotCtrl[fIdx] = cfgWdata & std_pkg::SLOT_CTRL_WMASK; // RULE8
                if (fIdx)
                    next_slotCtrl[fIdx][std_pkg::SC_DOCK_EN] = 1'b0;       // RULE9
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hfCtrl   <= std_pkg::HOST_FEAT_RST;                           // RULE22
            slotCtrl <= {NS{std_pkg::SLOT_CTRL_RST}};
            strapReg <= 4'h0;
            strapCnt <= 2'h0;
            cfgAck   <= 1'b0;
            cfgRdata <= 8'h00;
        end else begin
            hfCtrl   <= next_hfCtrl;
            slotCtrl <= next_slotCtrl;
            strapReg <= next_strapReg;
            strapCnt <= next_strapCnt;
            cfgAck   <= next_cfgAck;
            cfgRdata <= next_cfgRdata;
        end
    end

    // pins and slot steering
    logic            next_clkrunOe;
    logic            next_spkOut;
    logic            next_spkOe;
    logic [1:0]      next_muxPciSel;
    logic [1:0]      next_secMasterEn;
    logic [1:0]      next_onlyDev0;
    logic [1:0]      next_ioLevel5;
    logic [1:0]      next_slewFast;
    logic [1:0][2:0] next_slotType;
    logic [1:0][2:0] next_slotVolt;
    logic            dockA;

    assign dockA = (detType[0] == std_pkg::TY_DOCK);

    always_comb begin
        // start while the host lets the line float high, or at once with a dock on slot A, then hold for the request
        next_clkrunOe = !hfCtrl[std_pkg::HF_CLKRUN_DIS]                    // RULE17
                        && (dockA                                          // RULE18
                            || (clkRunReq && (sClkrun || clkrunOe)));      // RULE16
        next_spkOut   = |sSpk;
        next_spkOe    = hfCtrl[std_pkg::HF_SPKR];                          // RULE20
        for (int s = 0; s < NS; s++) begin
            next_muxPciSel[s]   = (detType[s] == std_pkg::TY_CBUS)
                                  || (detType[s] == std_pkg::TY_DOCK);     // RULE7 RULE11
            next_secMasterEn[s] = next_muxPciSel[s];                       // RULE10
            next_onlyDev0[s]    = (detType[s] == std_pkg::TY_CBUS);        // RULE12
            next_ioLevel5[s]    = !next_muxPciSel[s]
                                  && slotCtrl[s][std_pkg::SC_PCM_LVL5];    // RULE8
            next_slewFast[s]    = next_muxPciSel[s]
                                  && slotCtrl[s][std_pkg::SC_PCI_SLEW];    // RULE8
            next_slotType[s]    = detType[s];                              // RULE1
            next_slotVolt[s]    = detVolt[s];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            clkrunOut       <= 1'b0;
            clkrunOe        <= 1'b0;
            speakerOutDrive <= 1'b0;
            speakerOe       <= 1'b0;
            muxPciSel       <= '0;
            secMasterEn     <= '0;
            onlyDev0        <= '0;
            ioLevel5        <= '0;
            slewFast        <= '0;
            slotType        <= '0;
            slotVolt        <= '0;
        end else begin
            clkrunOut       <= 1'b0;
            clkrunOe        <= next_clkrunOe;
            speakerOutDrive <= next_spkOut;
            speakerOe       <= next_spkOe;
            muxPciSel       <= next_muxPciSel;
            secMasterEn     <= next_secMasterEn;
            onlyDev0        <= next_onlyDev0;
            ioLevel5        <= next_ioLevel5;
            slewFast        <= next_slewFast;
            slotType        <= next_slotType;
            slotVolt        <= next_slotVolt;
        end
    end

    property p_cfg_ack;
        @(posedge core_clk) disable iff (!nrst)
        cfgReq && cfgFunc <= std_pkg::FUNC_B |=> cfgAck;
    endproperty
    a_cfg_ack: assert property (p_cfg_ack) else $error("claimed cycle not acked"); // RULE13

    property p_cfg_unclaimed;
        @(posedge core_clk) disable iff (!nrst)
        !cfgReq || cfgFunc > std_pkg::FUNC_B |=> !cfgAck;
    endproperty
    a_cfg_unclaimed: assert property (p_cfg_unclaimed) else $error("unclaimed ack"); // RULE13

    property p_clkrun_dis;
        @(posedge core_clk) disable iff (!nrst)
        hfCtrl[std_pkg::HF_CLKRUN_DIS] |=> !clkrunOe && !clkrunOut;
    endproperty
    a_clkrun_dis: assert property (p_clkrun_dis) else $error("clkrun driven while off"); // RULE17

    property p_dock_clk;
        @(posedge core_clk) disable iff (!nrst)
        dockA && !hfCtrl[std_pkg::HF_CLKRUN_DIS] |=> clkrunOe;
    endproperty
    a_dock_clk: assert property (p_dock_clk) else $error("dock without clock request"); // RULE18

    property p_spk_write;
        @(posedge core_clk) disable iff (!nrst)
        claim && cfgWr && cfgIndex == std_pkg::CFG_HOST_FEAT |=> ##1 speakerOe == $past(cfgWdata[1], 2);
    endproperty
    a_spk_write: assert property (p_spk_write) else $error("speaker enable wrong"); // RULE20

    property p_pcm_slave;
        @(posedge core_clk) disable iff (!nrst)
        detType[0] == std_pkg::TY_PCM |=> !muxPciSel[0] && !secMasterEn[0];
    endproperty
    a_pcm_slave: assert property (p_pcm_slave) else $error("16-bit card exposed pci"); // RULE10

    property p_cbus_dev0;
        @(posedge core_clk) disable iff (!nrst)
        detType[0] == std_pkg::TY_CBUS |=> onlyDev0[0] && muxPciSel[0];
    endproperty
    a_cbus_dev0: assert property (p_cbus_dev0) else $error("cardbus not device 0 only"); // RULE12

    property p_strap_ro;
        @(posedge core_clk) disable iff (!nrst)
        claim && cfgWr && cfgIndex == std_pkg::CFG_HOST_FEAT |=> hfCtrl[7:4] == 4'h0;
    endproperty
    a_strap_ro: assert property (p_strap_ro) else $error("strap bits written"); // RULE21
endmodule : std_host_ctrl

// file: tb/std_card_model.sv
// pad-level model of what sits in one slot: empty, 16-bit card, CardBus card or dock
// assumes kind is held by the bench between insertions
module std_card_model (
    // attachment: 0 empty, 1 16-bit 3.3V, 2 16-bit 5V, 3 CardBus 3.3V, 4 dock 3.3V, 5 dock 5V
    input  wire logic [2:0] kind,
    // pads
    output logic            cd1N,
    output logic            cd2N,
    output logic [1:0]      vs1,
    output logic [1:0]      vs2,
    output logic            lvKey
);
    localparam logic [1:0] OP = std_pkg::SENSE_OPEN;
    localparam logic [1:0] GN = std_pkg::SENSE_GND;
    localparam logic [1:0] C1 = std_pkg::SENSE_CD1;
    always_comb begin
        {cd1N, cd2N, vs1, vs2, lvKey} = {2'b11, OP, OP, 1'b0};
        case (kind)
            3'h1: {cd1N, cd2N, vs1, vs2, lvKey} = {2'b00, GN, OP, 1'b1};
            3'h2: {cd1N, cd2N, vs1, vs2, lvKey} = {2'b00, OP, OP, 1'b0};
            3'h3: {cd1N, cd2N, vs1, vs2, lvKey} = {2'b10, C1, OP, 1'b1};
            3'h4: {cd1N, cd2N, vs1, vs2, lvKey} = {2'b10, C1, GN, 1'b1};
            3'h5: {cd1N, cd2N, vs1, vs2, lvKey} = {2'b10, GN, C1, 1'b1};
            default: ;
        endcase
    end
endmodule : std_card_model

// file: tb/testbench.sv
// self-checking bench for the slot type detect and host feature controller
// assumes short debounce counts of 8 and 20 cycles
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic            core_clk, nrst, cfgReq, cfgWr, cfgAck, clkrunIn, clkRunReq;
    logic            clkrunOut, clkrunOe, speakerOutDrive, speakerOe, ack;
    logic [2:0]      cfgFunc, kindA, kindB;
    logic [7:0]      cfgIndex, cfgWdata, cfgRdata, rd;
    logic [1:0]      cd1N, cd2N, lowVoltageKey, muxPciSel, secMasterEn, onlyDev0, ioLevel5, slewFast;
    logic [1:0][1:0] vs1, vs2;
    logic [1:0]      spk;
    logic [1:0][2:0] slotType, slotVolt;
    int              num_errors = 0, compares = 0, cycles = 0;

    std_card_model i_std_card_model_a (.kind(kindA), .cd1N(cd1N[0]), .cd2N(cd2N[0]),
        .vs1(vs1[0]), .vs2(vs2[0]), .lvKey(lowVoltageKey[0]));
    std_card_model i_std_card_model_b (.kind(kindB), .cd1N(cd1N[1]), .cd2N(cd2N[1]),
        .vs1(vs1[1]), .vs2(vs2[1]), .lvKey(lowVoltageKey[1]));
    std_host_ctrl #(.DEB_SHORT_CYC(8), .DEB_LONG_CYC(20)) i_std_host_ctrl (.core_clk(core_clk),
        .nrst(nrst), .cd1N(cd1N), .cd2N(cd2N), .vs1(vs1), .vs2(vs2),
        .lowVoltageKey(lowVoltageKey), .slotSpeaker(spk), .strapPins(4'ha), .cfgReq(cfgReq),
        .cfgWr(cfgWr), .cfgFunc(cfgFunc), .cfgIndex(cfgIndex), .cfgWdata(cfgWdata),
        .cfgAck(cfgAck), .cfgRdata(cfgRdata), .clkrunIn(clkrunIn), .clkRunReq(clkRunReq),
        .clkrunOut(clkrunOut), .clkrunOe(clkrunOe), .speakerOutDrive(speakerOutDrive),
        .speakerOe(speakerOe), .muxPciSel(muxPciSel), .secMasterEn(secMasterEn),
        .onlyDev0(onlyDev0), .ioLevel5(ioLevel5), .slewFast(slewFast), .slotType(slotType),
        .slotVolt(slotVolt));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic results();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            results();
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle

    // one config access; read data taken in the acknowledge cycle
    task automatic cfg(input logic w, input logic [2:0] f, input logic [7:0] i, input logic [7:0] d);
        @(posedge core_clk) #1;
        {cfgReq, cfgWr, cfgFunc, cfgIndex, cfgWdata} = {1'b1, w, f, i, d};
        settle(1);
        cfgReq = 1'b0;
        ack = cfgAck;
        rd = cfgRdata;
    endtask : cfg

    // {ioLevel5, slewFast, muxPciSel, secMasterEn, onlyDev0, slotType} of slot A
    task automatic seeA(input logic [2:0] k, input logic [7:0] e);
        kindA = k;
        settle(20);
        chk({ioLevel5[0], slewFast[0], muxPciSel[0], secMasterEn[0], onlyDev0[0], slotType[0]}, e);
    endtask : seeA

    task automatic t_regs();
        cfg(0, 3'h0, 8'h50, 8'h00);
        chk(rd, 8'ha0);
        cfg(1, 3'h0, 8'h50, 8'hff);
        cfg(0, 3'h1, 8'h50, 8'h00);
        chk(rd, 8'hae);
        chk({7'h0, ack}, 8'h01);
        cfg(1, 3'h0, 8'h10, 8'hff);
        cfg(0, 3'h0, 8'h10, 8'h00);
        chk(rd, 8'h00);
        cfg(0, 3'h2, 8'h50, 8'h00);
        chk({7'h0, ack}, 8'h00);
        cfg(1, 3'h0, 8'h50, 8'h02);
        settle(1);
        chk({7'h0, speakerOe}, 8'h01);
        spk = 2'h2;
        settle(3);
        chk({7'h0, speakerOutDrive}, 8'h01);
        cfg(1, 3'h0, 8'h50, 8'h00);
        settle(1);
        chk({7'h0, speakerOe}, 8'h00);
    endtask : t_regs

    task automatic t_detect();
        cfg(1, 3'h0, 8'h55, 8'h02);
        seeA(3'h1, 8'h81);
        cfg(0, 3'h0, 8'h54, 8'h00);
        chk(rd, 8'h09);
        seeA(3'h2, 8'h81);
        cfg(0, 3'h0, 8'h54, 8'h00);
        chk(rd, 8'h11);
        seeA(3'h3, 8'h3a);
        seeA(3'h4, 8'h84);
        cfg(1, 3'h0, 8'h55, 8'h05);
        seeA(3'h4, 8'h73);
        chk({7'h0, clkrunOe}, 8'h01);
        seeA(3'h5, 8'h73);
        chk({5'h0, slotVolt[0]}, 8'h02);
        cfg(1, 3'h0, 8'h55, 8'h00);
        settle(2);
        chk({5'h0, slotType[0]}, 8'h04);
        seeA(3'h0, 8'h00);
        cfg(1, 3'h1, 8'h55, 8'h01);
        kindB = 3'h4;
        settle(20);
        chk({5'h0, slotType[1]}, 8'h04);
    endtask : t_detect

    task automatic t_clkrun();
        clkRunReq = 1'b1;
        settle(5);
        chk({6'h0, clkrunOe, clkrunOut}, 8'h02);
        cfg(1, 3'h0, 8'h50, 8'h04);
        settle(2);
        chk({7'h0, clkrunOe}, 8'h00);
        clkRunReq = 1'b0;
    endtask : t_clkrun

    task automatic t_debounce();
        cfg(1, 3'h0, 8'h50, 8'h08);
        kindA = 3'h1;
        settle(12);
        chk({5'h0, slotType[0]}, 8'h00);
        settle(20);
        chk({5'h0, slotType[0]}, 8'h01);
    endtask : t_debounce

    initial begin
        {nrst, cfgReq, cfgWr, clkRunReq, cfgFunc, cfgIndex, cfgWdata} = '0;
        {clkrunIn, kindA, kindB, spk} = {1'b1, 8'h0};
        repeat (2) @(posedge core_clk);
        #1 nrst = 1'b1;
        settle(5);
        t_regs();
        t_detect();
        t_clkrun();
        t_debounce();
        results();
    end
endmodule : testbench
